// File: rtl/uis_irq_sleep.sv
// Flags, interrupt masking and software sleep control of a serial UART
// Operation
// - Parity flag is one only when parity enabled and received parity one
// - Parity flag and interrupt follow the oldest receive FIFO word
// - Pending flag set while unread data exists or is being read
// - Interrupt held while pending flag and pending mask are both one
// - In sleep the shared flag catches any receive line transition
// - In sleep interrupt asserts on activity flag with its mask set
// - Awake, shared flag is framing error of current character only
// - Awake, interrupt asserts on framing error with its mask set
// - Send-idle flag shows buffer empty; interrupt when it becomes empty
// - Send-idle interrupt clears at 16th serial clock rise of data op
// - Sleep entered only after shift register and buffer finish sending
// - Sleep stops the oscillator
// - Acknowledge set on entering sleep; host then powers transceivers down
// - Entering sleep empties FIFO and clears flags, sets send-idle
// - Configuration bits stay writable while asleep
// - Clearing sleep request restarts oscillator when chip select rises
// - Software sleep touches UART logic only, never the transceivers
// - Word bits 15,14,10,8 carry pending, idle, activity/frame, parity
// - A data transfer releases interrupt unless a source still holds
`timescale 1ns/1ps
module uis_irq_sleep #(
  parameter int unsigned DEPTH = uis_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic rxLine,
  input wire logic dataOp,
  input wire logic cfgWrite,
  input wire logic sleep_request,
  input wire logic parity_irq_mask,
  input wire logic data_pending_mask,
  input wire logic actframe_mask,
  input wire logic send_idle_mask,
  input wire logic parity_enable,
  input wire logic rxWordValid,
  input wire logic [7:0] rxWordData,
  input wire logic rxWordParity,
  input wire logic rxWordFrameErr,
  input wire logic rxPop,
  input wire logic txBufLoaded,
  input wire logic txBufTaken,
  input wire logic txShiftBusy,
  input wire logic txParityIn,
  output logic rxWordReady,
  output logic [7:0] received_byte,
  output logic parity_in_flag,
  output logic data_pending,
  output logic activity_or_framing_flag,
  output logic send_idle,
  output logic tx_parity_value,
  output logic sleep_acknowledge,
  output logic oscEnable,
  output logic [15:0] statusWord,
  output logic irqN
);
  // ------------------------------------------------------------
  // Synchronised pins
  // ------------------------------------------------------------
  logic csS, sclkS, rxS;
  logic csD, sclkD, rxD;
  uis_sync #(.INIT(1'b1)) uCs (.clk(clk), .rst(rst), .din(csN), .dout(csS));
  uis_sync uSclk (.clk(clk), .rst(rst), .din(sclk), .dout(sclkS));
  uis_sync #(.INIT(1'b1)) uRx (.clk(clk), .rst(rst), .din(rxLine),
    .dout(rxS));

  // Delayed copies for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      csD <= 1'b1;
      sclkD <= 1'b0;
      rxD <= 1'b1;
    end else begin
      csD <= csS;
      sclkD <= sclkS;
      rxD <= rxS;
    end
  end

  logic csRise, csFall, sclkRise, rxEdge;
  assign csRise = csS & ~csD;
  assign csFall = ~csS & csD;
  assign sclkRise = sclkS & ~sclkD;
  assign rxEdge = rxS ^ rxD;

  // ------------------------------------------------------------
  // Sleep sequencing
  // ------------------------------------------------------------
  uis_pkg::uis_sleep_e state;
  logic enterSleep;
  // Request must still stand, or flags would clear without sleeping
  assign enterSleep = (state == uis_pkg::SL_DRAIN) & sleep_request &
                      ~txShiftBusy & send_idle;

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= uis_pkg::SL_RUN;
    end else begin
      unique case (state)
        uis_pkg::SL_RUN: begin
          if (sleep_request) begin
            state <= uis_pkg::SL_DRAIN;
          end
        end
        uis_pkg::SL_DRAIN: begin
          if (!sleep_request) begin
            state <= uis_pkg::SL_RUN;
          end else if (enterSleep) begin
            state <= uis_pkg::SL_SLEEP;
          end
        end
        uis_pkg::SL_SLEEP: begin
          if (!sleep_request) begin
            state <= uis_pkg::SL_WAKE;
          end
        end
        uis_pkg::SL_WAKE: begin
          if (sleep_request) begin
            state <= uis_pkg::SL_SLEEP;
          end else if (csRise) begin
            state <= uis_pkg::SL_RUN;
          end
        end
      endcase
    end
  end

  logic asleep;
  assign asleep = (state == uis_pkg::SL_SLEEP) |
                  (state == uis_pkg::SL_WAKE);
  // Acknowledge and oscillator gate; transceivers are not touched here
  assign sleep_acknowledge = asleep;
  assign oscEnable = ~asleep;

  // ------------------------------------------------------------
  // Receive FIFO
  // ------------------------------------------------------------
  localparam int unsigned AW = $clog2(DEPTH);
  logic [9:0] mem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr;
  logic [AW:0] count;
  logic push, pop;
  assign rxWordReady = (count != DEPTH[AW:0]) & ~asleep;
  assign push = rxWordValid & rxWordReady;
  assign pop = rxPop & (count != '0);

  // Storage holds data and parity; framing error is not queued
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= {rxWordParity, 1'b0, rxWordData};
    end
  end

  // Pointers and count; entering sleep empties the FIFO
  always_ff @(posedge clk) begin
    if (rst || enterSleep) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Read in progress keeps the pending flag up
  logic reading;
  always_ff @(posedge clk) begin
    if (rst || enterSleep) begin
      reading <= 1'b0;
    end else if (csFall && count != '0) begin
      reading <= 1'b1;
    end else if (csRise) begin
      reading <= 1'b0;
    end
  end

  logic [9:0] head;
  assign head = mem[rdPtr];

  // Oldest word outputs and flags
  always_ff @(posedge clk) begin
    if (rst || enterSleep) begin
      received_byte <= 8'h00;
      parity_in_flag <= 1'b0;
      data_pending <= 1'b0;
    end else begin
      received_byte <= (count != '0) ? head[7:0] : 8'h00;
      parity_in_flag <= (count != '0) & parity_enable & head[9];
      data_pending <= (count != '0) | reading;
    end
  end

  // ------------------------------------------------------------
  // Activity / framing flag
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || enterSleep || (state == uis_pkg::SL_WAKE && csRise)) begin
      activity_or_framing_flag <= 1'b0;
    end else if (asleep) begin
      if (rxEdge) begin
        activity_or_framing_flag <= 1'b1;
      end
    end else if (rxWordValid) begin
      activity_or_framing_flag <= rxWordFrameErr;
    end
  end

  // ------------------------------------------------------------
  // Transmit buffer flag, parity and send-idle interrupt
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || enterSleep) begin
      send_idle <= 1'b1;
      tx_parity_value <= 1'b0;
    end else begin
      if (txBufLoaded) begin
        send_idle <= 1'b0;
        tx_parity_value <= txParityIn;
      end else if (txBufTaken) begin
        send_idle <= 1'b1;
      end
    end
  end

  // Serial clock count within the current frame
  logic [4:0] sclkCount;
  always_ff @(posedge clk) begin
    if (rst || csFall) begin
      sclkCount <= 5'h00;
    end else if (sclkRise && !csS && sclkCount != uis_pkg::LAST_SCLK) begin
      sclkCount <= sclkCount + 5'h01;
    end
  end

  logic idleIrq, idleClr, idleRise, idleD;
  assign idleClr = sclkRise & ~csS & dataOp &
                   (sclkCount == uis_pkg::LAST_SCLK - 5'h01);
  assign idleRise = send_idle & ~idleD;

  // Sticky send-idle event; a new emptying wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      idleD <= 1'b1;
      idleIrq <= 1'b0;
    end else begin
      idleD <= send_idle;
      if (idleRise) begin
        idleIrq <= 1'b1;
      end else if (idleClr) begin
        idleIrq <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt output and status word
  // ------------------------------------------------------------
  logic [3:0] srcOn;
  assign srcOn[0] = parity_in_flag & parity_irq_mask;
  assign srcOn[1] = data_pending & data_pending_mask;
  assign srcOn[2] = activity_or_framing_flag & actframe_mask;
  assign srcOn[3] = idleIrq & send_idle_mask;
  assign irqN = ~(|srcOn);

  // Mask and config bits are plain inputs, so they stay writable asleep
  logic unusedCfg;
  assign unusedCfg = cfgWrite;

  // Response word, captured as chip select falls
  always_ff @(posedge clk) begin
    if (rst) begin
      statusWord <= 16'h0000;
    end else if (csFall) begin
      statusWord <= 16'h0000;
      statusWord[uis_pkg::BIT_PENDING] <= data_pending;
      statusWord[uis_pkg::BIT_SENDIDLE] <= send_idle;
      statusWord[uis_pkg::BIT_ACTFRAME] <= activity_or_framing_flag;
      statusWord[uis_pkg::BIT_PARITY] <= parity_in_flag;
      statusWord[7:0] <= received_byte;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Interrupt, flag and status word checks
  pending_irq_a: assert property (@(posedge clk) disable iff (rst)
    data_pending && data_pending_mask |-> !irqN)
    else $error("pending source did not hold interrupt");
  parity_gate_a: assert property (@(posedge clk) disable iff (rst)
    !$past(parity_enable) |-> !parity_in_flag)
    else $error("parity flag set with parity disabled");
  pending_flag_a: assert property (@(posedge clk) disable iff (rst)
    count != '0 && !enterSleep |=> data_pending)
    else $error("pending flag low with data held");
  frame_follow_a: assert property (@(posedge clk) disable iff (rst)
    !asleep && !enterSleep && rxWordValid
      |=> activity_or_framing_flag == $past(rxWordFrameErr))
    else $error("framing flag does not follow character");
  idle_set_a: assert property (@(posedge clk) disable iff (rst)
    $rose(send_idle) |=> idleIrq)
    else $error("send idle interrupt not raised");
  idle_clear_a: assert property (@(posedge clk) disable iff (rst)
    idleClr && !idleRise |=> !idleIrq)
    else $error("send idle interrupt not cleared");
  irq_none_a: assert property (@(posedge clk) disable iff (rst)
    srcOn == 4'h0 |-> irqN)
    else $error("interrupt without source");
  status_word_a: assert property (@(posedge clk) disable iff (rst)
    csFall |=> statusWord[uis_pkg::BIT_PENDING] == $past(data_pending)
      && statusWord[uis_pkg::BIT_PARITY] == $past(parity_in_flag))
    else $error("status word flags wrong");
  // Sleep sequencing checks
  sleep_wait_a: assert property (@(posedge clk) disable iff (rst)
    $rose(sleep_acknowledge) |-> $past(!txShiftBusy && send_idle))
    else $error("sleep entered while sending");
  sleep_clear_a: assert property (@(posedge clk) disable iff (rst)
    $rose(sleep_acknowledge) |-> !data_pending && send_idle
      && !activity_or_framing_flag && !parity_in_flag
      && !tx_parity_value && count == '0 && received_byte == 8'h00)
    else $error("sleep entry did not clear flags");
  rx_refuse_a: assert property (@(posedge clk) disable iff (rst)
    asleep |-> !rxWordReady)
    else $error("receive word accepted while asleep");
  osc_gate_a: assert property (@(posedge clk) disable iff (rst)
    oscEnable != sleep_acknowledge)
    else $error("oscillator runs in sleep");
  wake_cs_a: assert property (@(posedge clk) disable iff (rst)
    state == uis_pkg::SL_WAKE && csRise && !sleep_request |=> oscEnable)
    else $error("no wake at chip select rise");
  activity_set_a: assert property (@(posedge clk) disable iff (rst)
    state == uis_pkg::SL_SLEEP && rxEdge && sleep_request
      |=> activity_or_framing_flag)
    else $error("receive activity missed in sleep");
endmodule : uis_irq_sleep

// File: rtl/uis_pkg.sv
// Package: constants for the UART interrupt and sleep control block
package uis_pkg;
  // ------------------------------------------------------------
  // Status word bit positions
  // ------------------------------------------------------------
  localparam int unsigned BIT_PENDING = 15;
  localparam int unsigned BIT_SENDIDLE = 14;
  localparam int unsigned BIT_ACTFRAME = 10;
  localparam int unsigned BIT_PARITY = 8;
  // ------------------------------------------------------------
  // Link and counts
  // ------------------------------------------------------------
  localparam int unsigned WORD_BITS = 16;
  localparam logic [4:0] LAST_SCLK = 5'h10;
  localparam int unsigned FIFO_DEPTH = 8;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [3:0] RST_MASKS = 4'h0;
  localparam logic RST_SLEEP = 1'b0;
  // ------------------------------------------------------------
  // Sleep sequencing states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SL_RUN = 4'b0001,
    SL_DRAIN = 4'b0010,
    SL_SLEEP = 4'b0100,
    SL_WAKE = 4'b1000
  } uis_sleep_e;
endpackage : uis_pkg

// File: rtl/uis_sync.sv
// Two-flop synchroniser for one bit from outside the clock domain
`timescale 1ns/1ps
module uis_sync #(
  parameter logic INIT = 1'b0 // Idle level of the pin, avoids a false edge
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic stage1;
  // Two flip-flops; only the second stage is read outside
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= INIT;
      dout <= INIT;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : uis_sync

// File: verif/uis_host_model.sv
// Host model: frames chip select and serial clock on request
`timescale 1ns/1ps
module uis_host_model (
  input wire logic go,
  input wire logic op,
  output logic csN,
  output logic sclk,
  output logic dataOp,
  output logic done
);
  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  // Serial clock idles low between frames; phase offset from clk
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    dataOp = 1'b0;
    done = 1'b0;
    forever begin
      wait (go === 1'b1);
      #7;
      dataOp = op;
      csN = 1'b0;
      #80;
      repeat (16) begin
        sclk = 1'b1;
        #80;
        sclk = 1'b0;
        #80;
      end
      csN = 1'b1;
      #80;
      dataOp = 1'b0;
      done = 1'b1;
      wait (go === 1'b0);
      done = 1'b0;
    end
  end
endmodule : uis_host_model

// File: verif/uis_irq_sleep_test.sv
// Self-checking bench for the flag, interrupt and sleep block
`timescale 1ns/1ps
module uis_irq_sleep_test;
  logic clk, rst, go, op, csN, sclk, dataOp, done, rxLine, cfgWr;
  logic slpReq, pMask, dMask, aMask, tMask, pEn;
  logic rxV, rxP, rxF, rxPop, txLd, txTk, txBusy, txPar;
  logic rxRdy, pFlag, pend, afFlag, sIdle, txPv, ack, osc, irqN;
  logic [7:0] rxD, rxByte;
  logic [15:0] stat;
  int n_mismatch, comparisons;
  // ----------------------------------------
  // Instances and clock
  // ----------------------------------------
  uis_host_model uis_host_model_inst (.go(go), .op(op), .csN(csN),
    .sclk(sclk), .dataOp(dataOp), .done(done));
  uis_irq_sleep uis_irq_sleep_inst (.clk(clk), .rst(rst), .csN(csN),
    .sclk(sclk), .rxLine(rxLine), .dataOp(dataOp), .cfgWrite(cfgWr),
    .sleep_request(slpReq), .parity_irq_mask(pMask),
    .data_pending_mask(dMask), .actframe_mask(aMask),
    .send_idle_mask(tMask), .parity_enable(pEn), .rxWordValid(rxV),
    .rxWordData(rxD), .rxWordParity(rxP), .rxWordFrameErr(rxF),
    .rxPop(rxPop), .txBufLoaded(txLd), .txBufTaken(txTk),
    .txShiftBusy(txBusy), .txParityIn(txPar), .rxWordReady(rxRdy),
    .received_byte(rxByte), .parity_in_flag(pFlag),
    .data_pending(pend), .activity_or_framing_flag(afFlag),
    .send_idle(sIdle), .tx_parity_value(txPv),
    .sleep_acknowledge(ack), .oscEnable(osc), .statusWord(stat),
    .irqN(irqN));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task frame(input logic d);
    int i;
    go = 1'b1;
    op = d;
    for (i = 0; i < 400 && done !== 1'b1; i++) tick(1);
    if (i == 400) begin
      n_mismatch++;
      summarize();
    end
    go = 1'b0;
    tick(6);
  endtask : frame
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
  endtask : pulse
  task push(input logic [7:0] d, input logic p, input logic f);
    rxD = d;
    rxP = p;
    rxF = f;
    pulse(rxV);
  endtask : push
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_rx();
    pEn = 1'b0;
    push(8'h11, 1'b1, 1'b0);
    chk("parity off", 16'h0000, pFlag);
    pulse(rxPop);
    pEn = 1'b1;
    dMask = 1'b1;
    push(8'hA5, 1'b1, 1'b0);
    push(8'h3C, 1'b0, 1'b0);
    chk("parity", 16'h0001, pFlag);
    chk("pending", 16'h0001, pend);
    chk("irq pend", 16'h0000, irqN);
    frame(1'b1);
    chk("status", 16'hC1A5, stat);
    pulse(rxPop);
    chk("parity next", 16'h0000, pFlag);
    chk("byte next", 16'h003C, rxByte);
    pulse(rxPop);
    chk("pending off", 16'h0000, pend);
    chk("irq free", 16'h0001, irqN);
    dMask = 1'b0;
    pMask = 1'b1;
    push(8'h02, 1'b1, 1'b0);
    chk("irq parity", 16'h0000, irqN);
    pulse(rxPop);
    chk("irq parity off", 16'h0001, irqN);
  endtask : t_rx
  task t_frameerr();
    aMask = 1'b1;
    push(8'h00, 1'b0, 1'b1);
    chk("frame err", 16'h0001, afFlag);
    chk("irq frame", 16'h0000, irqN);
    push(8'h01, 1'b0, 1'b0);
    chk("frame ok", 16'h0000, afFlag);
    pulse(rxPop);
    pulse(rxPop);
    chk("irq none", 16'h0001, irqN);
  endtask : t_frameerr
  task t_idle();
    tMask = 1'b1;
    txPar = 1'b1;
    pulse(txLd);
    chk("idle full", 16'h0000, sIdle);
    chk("tx parity", 16'h0001, txPv);
    pulse(txTk);
    chk("idle empty", 16'h0001, sIdle);
    chk("irq idle", 16'h0000, irqN);
    frame(1'b0);
    chk("irq kept", 16'h0000, irqN);
    frame(1'b1);
    chk("irq cleared", 16'h0001, irqN);
    chk("idle polled", 16'h0001, sIdle);
    tMask = 1'b0;
  endtask : t_idle
  task t_sleep();
    int i;
    push(8'h77, 1'b1, 1'b0);
    txBusy = 1'b1;
    slpReq = 1'b1;
    tick(10);
    chk("ack early", 16'h0000, ack);
    txBusy = 1'b0;
    for (i = 0; i < 50 && ack !== 1'b1; i++) tick(1);
    if (i == 50) begin
      n_mismatch++;
      summarize();
    end
    chk("ack", 16'h0001, ack);
    chk("osc off", 16'h0000, osc);
    chk("flags", 16'h0000, {pend, pFlag, txPv, afFlag, rxByte});
    chk("idle set", 16'h0001, sIdle);
    chk("refused", 16'h0000, rxRdy);
    rxLine = 1'b0;
    tick(5);
    chk("activity", 16'h0001, afFlag);
    chk("irq act", 16'h0000, irqN);
    aMask = 1'b0;
    tick(1);
    chk("mask asleep", 16'h0001, irqN);
    aMask = 1'b1;
    rxLine = 1'b1;
    slpReq = 1'b0;
    tick(5);
    chk("ack held", 16'h0001, ack);
    frame(1'b0);
    chk("woken", 16'h0002, {ack, osc, afFlag});
    tick(20);
    pulse(cfgWr);
    chk("rx ready", 16'h0001, rxRdy);
  endtask : t_sleep
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, go, op, rxLine, cfgWr, slpReq, pMask, dMask, aMask} = 9'h120;
    {tMask, pEn, rxV, rxP, rxF, rxPop, txLd, txTk, txBusy, txPar} = 10'h0;
    rxD = 8'h00;
    n_mismatch = 0;
    comparisons = 0;
    tick(6);
    rst = 1'b0;
    tick(1);
    chk("reset", 16'h000D, {irqN, sIdle, pend, osc});
    chk("reset ack", 16'h0000, ack);
    t_rx();
    t_frameerr();
    t_idle();
    t_sleep();
    summarize();
  end
endmodule : uis_irq_sleep_test
